//--- logic/ecl_regs.svh
// configuration-space offsets, field positions and loader constants
`ifndef ECL_REGS_SVH
`define ECL_REGS_SVH

// configuration dword byte offsets
`define ECL_OFS_IDENT        8'h00
`define ECL_OFS_CMD_STATUS   8'h04
`define ECL_OFS_REVISION     8'h08
`define ECL_OFS_MEM_BAR      8'h10
`define ECL_OFS_BOARD        8'h2c
`define ECL_OFS_CAP_PTR      8'h34
`define ECL_OFS_LINE_GNT_LAT 8'h3c
`define ECL_OFS_POWER_CAP    8'h50
`define ECL_OFS_POWER_CTRL   8'h54

// serial rom word addresses
`define ECL_WORD_CONFIG      4'h0
`define ECL_WORD_CHIP_CTRL   4'h1
`define ECL_WORD_BOARD_MAKER 4'h2
`define ECL_WORD_BOARD_ID    4'h3
`define ECL_WORD_LAST        4'h6

// config_param_word bit positions
`define ECL_CP_FAST          0
`define ECL_CP_BELOW_1MB     1
`define ECL_CP_BAR_OFF       2
`define ECL_CP_COLD_WAKE     3
`define ECL_CP_LIGHT_SLEEP   4
`define ECL_CP_DEEP_SLEEP    5
`define ECL_CP_WAKE_EN       6
`define ECL_CP_GNT_LSB       7
`define ECL_CP_LAT_LSB       11

// power_control_status bit positions
`define ECL_PC_WAKE_EN       8
`define ECL_PC_SEL_LSB       9
`define ECL_PC_SCALE_LSB     13
`define ECL_PC_WAKE_STAT     15

// reset values
`define ECL_BOARD_RST        16'h0000
`define ECL_POWER_CAP_ID     8'h01
`define ECL_POWER_CAP_VER    3'h2

`endif

//--- logic/ecl_pkg.sv
// types shared by the configuration autoload block
package ecl_pkg;

	// loader sequence
	typedef enum logic [1:0] {
		LD_IDLE,
		LD_REQ,
		LD_WAIT,
		LD_DONE
	} ecl_load_t;

	// data scale codes
	typedef enum logic [1:0] {
		SCALE_UNKNOWN,
		SCALE_TENTH,
		SCALE_HUNDREDTH,
		SCALE_THOUSANDTH
	} ecl_scale_t;

	// whole block state
	typedef struct packed {
		ecl_load_t   st;
		logic [3:0]  word;
		logic        rom_req;
		logic        done;
		logic [15:0] board_maker;
		logic [15:0] board_id;
		logic        fast_cap;
		logic        below_1mb;
		logic        bar_off;
		logic        cold_wake;
		logic        light_cap;
		logic        deep_cap;
		logic [3:0]  min_gnt;
		logic [4:0]  max_lat;
		logic [24:0] bar_base;
		logic [7:0]  int_line;
		logic [1:0]  pstate;
		logic        wake_en;
		logic [3:0]  data_sel;
		logic        wake_stat;
		logic [31:0] rdata;
		logic        ack;
		logic        wake_out;
		logic        wake_s1;
		logic        wake_s2;
		logic        wake_s3;
	} ecl_state_t;

endpackage

//--- logic/ecl_autoload.sv
// serial rom autoload into configuration-space fields
//
// Functional notes
// [RL1] data scale reports unknown, 0.1, 0.01, 0.001
// [RL2] wake status sets on wake, ignoring enable
// [RL3] revision byte at 0x08, read only
// [RL4] board id from rom word 3, read only
// [RL5] board maker at 0x2c, zero reset, word 2
// [RL6] fixed maker id at offset 0x00
// [RL7] rom words decoded by address
// [RL8] words 7 and above have no effect
// [RL9] config bit 0 sets fast consecutive cap
// [RL10] config bit 1 sets memory map kind bit 2
// [RL11] config bit 2 disables memory window bar
// [RL12] config bit 3 loads wake mask bit 15
// [RL13] config bit 4 loads light sleep, mask 12
// [RL14] config bit 5 loads deep sleep, mask 13
// [RL15] config bit 6 presets wake event enable
// [RL16] config bits 10:7 load min grant 7:4
// [RL17] config bits 15:11 load max latency 5:1
// [RL18] wake mask bits 14 and 11 always one
// [RL19] load after reset, in order, defaults before
// [RL20] loaded read-only fields ignore host writes
`timescale 1ns/1ns
`include "ecl_regs.svh"

module ecl_autoload
	import ecl_pkg::*;
#(
	parameter logic [15:0] MAKER_ID    = 16'h0a5a, // arbitrary value
	parameter logic [15:0] DEVICE_ID   = 16'h0001, // arbitrary value
	parameter logic [7:0]  REVISION_ID = 8'h01,    // arbitrary value
	parameter logic [31:0] SCALE_MAP   = 32'h0000_0000,
	parameter int          BAR_BITS    = 7
) (
	// clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	// configuration cycles
	input  wire logic        cfg_req_in,
	input  wire logic        cfg_write_in,
	input  wire logic [7:0]  cfg_addr_in,
	input  wire logic [3:0]  cfg_byte_en_in,
	input  wire logic [31:0] cfg_wdata_in,
	output logic      [31:0] cfg_rdata_out,
	output logic             cfg_ack_out,
	// serial rom word port
	output logic             rom_req_out,
	output logic      [3:0]  rom_addr_out,
	input  wire logic [15:0] rom_data_in,
	input  wire logic        rom_valid_in,
	// power management, bar enable and load status
	input  wire logic        wake_event_in,
	output logic             wake_out,
	output logic      [1:0]  power_state_out,
	output logic             mem_bar_enable_out,
	output logic             load_done_out
);

	ecl_state_t state_reg;
	ecl_state_t state_next;
	logic [31:0] rd_word;
	logic        wake_edge;
	logic        wr_hit;

	// scale factor of the selected data item
	function automatic ecl_scale_t scale_of(input logic [3:0] sel);
		scale_of = ecl_scale_t'(SCALE_MAP[{sel, 1'b0} +: 2]);
	endfunction

	// write enable of one byte lane for the addressed dword
	function automatic logic lane(input logic [7:0] ofs, input int b);
		lane = wr_hit && cfg_addr_in == ofs && cfg_byte_en_in[b];
	endfunction

	// read multiplexer over the configuration header
	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (cfg_addr_in)
			`ECL_OFS_IDENT:
				rd_word = {DEVICE_ID, MAKER_ID}; // [RL6]
			`ECL_OFS_CMD_STATUS:
				rd_word = {8'h00, state_reg.fast_cap, 3'h0, 1'b1, 3'h0, 16'h0000}; // [RL9]
			`ECL_OFS_REVISION:
				rd_word = {24'h00_0000, REVISION_ID}; // [RL3]
			`ECL_OFS_MEM_BAR:
				if (!state_reg.bar_off) begin // [RL11]
					rd_word = {state_reg.bar_base, {(BAR_BITS - 4){1'b0}},
						1'b0, state_reg.below_1mb, 1'b0, 1'b0}; // [RL10]
				end
			`ECL_OFS_BOARD:
				rd_word = {state_reg.board_id, state_reg.board_maker}; // [RL4] [RL5]
			`ECL_OFS_CAP_PTR:
				rd_word = {24'h00_0000, `ECL_OFS_POWER_CAP};
			`ECL_OFS_LINE_GNT_LAT:
				rd_word = {2'b00, state_reg.max_lat, 1'b0, state_reg.min_gnt, 4'h0, // [RL16] [RL17]
					8'h01, state_reg.int_line};
			`ECL_OFS_POWER_CAP:
				rd_word = {state_reg.cold_wake, 1'b1, state_reg.deep_cap, // [RL12] [RL14]
					state_reg.light_cap, 1'b1, // [RL13] [RL18]
					state_reg.deep_cap, state_reg.light_cap, 6'h00,
					`ECL_POWER_CAP_VER, 8'h00, `ECL_POWER_CAP_ID};
			`ECL_OFS_POWER_CTRL:
				rd_word = {16'h0000, state_reg.wake_stat, scale_of(state_reg.data_sel), // [RL1]
					state_reg.data_sel, state_reg.wake_en, 6'h00, state_reg.pstate};
			default:
				rd_word = 32'h0000_0000;
		endcase
	end

	assign wake_edge = state_reg.wake_s2 && !state_reg.wake_s3;
	assign wr_hit    = cfg_req_in && cfg_write_in;

	// next state of loader, registers and answers
	always_comb begin
		state_next = state_reg;
		// wake pin synchroniser and edge
		state_next.wake_s1 = wake_event_in;
		state_next.wake_s2 = state_reg.wake_s1;
		state_next.wake_s3 = state_reg.wake_s2;

		// configuration answer, one cycle after the request
		state_next.ack   = cfg_req_in;
		state_next.rdata = (cfg_req_in && !cfg_write_in) ? rd_word : 32'h0000_0000;

		// host writes reach only the writable fields
		if (lane(`ECL_OFS_MEM_BAR, 3) && !state_reg.bar_off) begin
			state_next.bar_base[24 -: 8] = cfg_wdata_in[31:24];
		end
		if (lane(`ECL_OFS_MEM_BAR, 2) && !state_reg.bar_off) begin
			state_next.bar_base[16 -: 8] = cfg_wdata_in[23:16];
		end
		if (lane(`ECL_OFS_MEM_BAR, 1) && !state_reg.bar_off) begin
			state_next.bar_base[8 -: 8] = cfg_wdata_in[15:8];
		end
		if (lane(`ECL_OFS_MEM_BAR, 0) && !state_reg.bar_off) begin
			state_next.bar_base[0] = cfg_wdata_in[7];
		end
		if (lane(`ECL_OFS_LINE_GNT_LAT, 0)) begin
			state_next.int_line = cfg_wdata_in[7:0];
		end
		if (lane(`ECL_OFS_POWER_CTRL, 0)) begin
			state_next.pstate = cfg_wdata_in[1:0];
		end
		if (lane(`ECL_OFS_POWER_CTRL, 1)) begin
			state_next.wake_en  = cfg_wdata_in[`ECL_PC_WAKE_EN];
			state_next.data_sel = cfg_wdata_in[`ECL_PC_SEL_LSB +: 4];
			if (cfg_wdata_in[`ECL_PC_WAKE_STAT]) begin
				state_next.wake_stat = 1'b0;
			end
		end
		// a wake event beats a clear in the same cycle
		if (wake_edge) begin
			state_next.wake_stat = 1'b1; // [RL2]
		end
		state_next.wake_out = state_next.wake_stat && state_next.wake_en;

		// autoload sequence over rom words 0 to 6
		state_next.rom_req = 1'b0;
		unique case (state_reg.st)
			LD_IDLE: begin
				state_next.word = `ECL_WORD_CONFIG; // [RL19]
				state_next.st   = LD_REQ;
			end
			LD_REQ: begin
				state_next.rom_req = 1'b1;
				state_next.st      = LD_WAIT;
			end
			LD_WAIT: begin
				if (rom_valid_in) begin
					unique case (state_reg.word) // [RL7]
						`ECL_WORD_CONFIG: begin
							state_next.fast_cap  = rom_data_in[`ECL_CP_FAST]; // [RL9]
							state_next.below_1mb = rom_data_in[`ECL_CP_BELOW_1MB]; // [RL10]
							state_next.bar_off   = rom_data_in[`ECL_CP_BAR_OFF]; // [RL11]
							state_next.cold_wake = rom_data_in[`ECL_CP_COLD_WAKE]; // [RL12]
							state_next.light_cap = rom_data_in[`ECL_CP_LIGHT_SLEEP]; // [RL13]
							state_next.deep_cap  = rom_data_in[`ECL_CP_DEEP_SLEEP]; // [RL14]
							state_next.wake_en   = rom_data_in[`ECL_CP_WAKE_EN]; // [RL15]
							state_next.min_gnt   = rom_data_in[`ECL_CP_GNT_LSB +: 4]; // [RL16]
							state_next.max_lat   = rom_data_in[`ECL_CP_LAT_LSB +: 5]; // [RL17]
						end
						`ECL_WORD_BOARD_MAKER:
							state_next.board_maker = rom_data_in; // [RL5]
						`ECL_WORD_BOARD_ID:
							state_next.board_id = rom_data_in; // [RL4]
						default: begin
							// chip control, base and indicator words are read and not stored
						end
					endcase
					if (state_reg.word == `ECL_WORD_LAST) begin
						state_next.st   = LD_DONE; // [RL8]
						state_next.done = 1'b1;
					end else begin
						state_next.word = state_reg.word + 4'h1; // [RL19]
						state_next.st   = LD_REQ;
					end
				end
			end
			LD_DONE: begin
				state_next.st = LD_DONE; // [RL20]
			end
		endcase
	end

	// single state register
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg             <= '0;
			state_reg.st          <= LD_IDLE;
			state_reg.board_maker <= `ECL_BOARD_RST; // [RL5]
			state_reg.board_id    <= `ECL_BOARD_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from the state register
	assign cfg_rdata_out      = state_reg.rdata;
	assign cfg_ack_out        = state_reg.ack;
	assign rom_req_out        = state_reg.rom_req;
	assign rom_addr_out       = state_reg.word;
	assign wake_out           = state_reg.wake_out;
	assign power_state_out    = state_reg.pstate;
	assign mem_bar_enable_out = !state_reg.bar_off;
	assign load_done_out      = state_reg.done;

endmodule // ecl_autoload

//--- sim/ecl_autoload_chk.sv
// assertion checker for the configuration autoload block
`timescale 1ns/1ns
module ecl_autoload_chk #(
	parameter logic [15:0] MAKER_ID    = 16'h0a5a,
	parameter logic [7:0]  REVISION_ID = 8'h01
) (
	input wire logic        sys_clk_in,
	input wire logic        rst_in,
	input wire logic        cfg_req_in,
	input wire logic        cfg_write_in,
	input wire logic [7:0]  cfg_addr_in,
	input wire logic [31:0] cfg_rdata_out,
	input wire logic        rom_req_out,
	input wire logic [3:0]  rom_addr_out,
	input wire logic [15:0] rom_data_in,
	input wire logic        rom_valid_in,
	input wire logic        mem_bar_enable_out,
	input wire logic        load_done_out
);
	logic        rd;
	logic [15:0] cp_reg;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	// plain read request
	assign rd = cfg_req_in & ~cfg_write_in;
	// copy of the stored config word
	always_ff @(posedge sys_clk_in) begin
		if (rom_valid_in && rom_addr_out == 4'h0)
			cp_reg <= rom_data_in;
	end
	chk_maker_read: assert property (rd && cfg_addr_in == 8'h00
		|=> cfg_rdata_out[15:0] == MAKER_ID) else $error("maker id wrong");
	chk_revision_read: assert property (rd && cfg_addr_in == 8'h08
		|=> cfg_rdata_out[7:0] == REVISION_ID) else $error("revision wrong");
	chk_board_default: assert property (rd && cfg_addr_in == 8'h2c && !load_done_out
		&& rom_addr_out < 4'h3 && !rom_valid_in |=> cfg_rdata_out[15:0] == 16'h0000)
		else $error("board maker not at default");
	chk_wake_mask: assert property (rd && cfg_addr_in == 8'h50 && load_done_out
		|=> cfg_rdata_out[31:25] == {cp_reg[3], 1'b1, cp_reg[5:4], 1'b1, cp_reg[5:4]})
		else $error("power capability wrong");
	chk_grant_latency: assert property (rd && cfg_addr_in == 8'h3c && load_done_out
		|=> {cfg_rdata_out[29:25], cfg_rdata_out[23:20]} == cp_reg[15:7])
		else $error("grant or latency wrong");
	chk_bar_off: assert property (rd && cfg_addr_in == 8'h10 && !mem_bar_enable_out
		|=> cfg_rdata_out == 32'h0) else $error("disabled bar reads nonzero");
	chk_done_last: assert property (rom_valid_in && rom_addr_out == 4'h6 && !load_done_out
		|=> load_done_out) else $error("load not done after last word");
	chk_word_order: assert property (rom_valid_in && rom_addr_out < 4'h6 && !load_done_out
		|=> rom_addr_out == $past(rom_addr_out) + 4'h1 ##1 rom_req_out)
		else $error("rom words out of order");
endmodule // ecl_autoload_chk

bind ecl_autoload ecl_autoload_chk #(.MAKER_ID(MAKER_ID), .REVISION_ID(REVISION_ID)) u_chk (
	.sys_clk_in, .rst_in, .cfg_req_in, .cfg_write_in, .cfg_addr_in, .cfg_rdata_out,
	.rom_req_out, .rom_addr_out, .rom_data_in, .rom_valid_in, .mem_bar_enable_out,
	.load_done_out);

//--- sim/ecl_rom_model.sv
// serial rom model answering word requests after a set delay
`timescale 1ns/1ns
module ecl_rom_model (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic [255:0] image_in,
	input  wire logic [3:0]   delay_in,
	input  wire logic         req_in,
	input  wire logic [3:0]   addr_in,
	output logic      [15:0]  data_out,
	output logic              valid_out
);
	logic       busy;
	logic [3:0] cnt;
	logic [3:0] word;
	// one word per request; data churns when not valid
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			busy <= 1'b0;
			valid_out <= 1'b0;
			data_out <= 16'h0000;
		end else begin
			valid_out <= 1'b0;
			data_out <= ~data_out;
			cnt <= cnt - 4'h1;
			if (req_in) begin
				busy <= 1'b1;
				cnt <= delay_in;
				word <= addr_in;
			end else if (busy && cnt == 4'h0) begin
				busy <= 1'b0;
				valid_out <= 1'b1;
				data_out <= image_in[word*16 +: 16];
			end
		end
	end
endmodule // ecl_rom_model

//--- sim/tb_top.sv
// self-checking bench for the configuration autoload block
`timescale 1ns/1ns
module tb_top;
	localparam logic [15:0] MAKER = 16'h0c3c; // arbitrary value
	localparam logic [7:0]  REV   = 8'h07;    // arbitrary value
	logic        sys_clk_in = 1'b0, rst_in = 1'b1, cfg_req_in = 1'b0, cfg_write_in = 1'b0;
	logic [7:0]  cfg_addr_in = 8'h00;
	logic [3:0]  cfg_byte_en_in = 4'h0, rom_addr_out, dly = 4'hf;
	logic [31:0] cfg_wdata_in = 32'h0, cfg_rdata_out, r;
	logic        cfg_ack_out, rom_req_out, rom_valid_in, wake_out, mem_bar_enable_out;
	logic        wake_event_in = 1'b0, load_done_out;
	logic [15:0] rom_data_in, w0 = 16'ha5d3;
	logic [7:0]  ro_addr [3] = '{8'h00, 8'h08, 8'h2c};
	int          errors = 0, compares = 0;
	// clock
	initial forever #5 sys_clk_in = ~sys_clk_in;
	ecl_autoload #(.MAKER_ID(MAKER), .REVISION_ID(REV), .SCALE_MAP(32'h0000_00e4)) u_dut (
		.sys_clk_in, .rst_in, .cfg_req_in, .cfg_write_in, .cfg_addr_in, .cfg_byte_en_in,
		.cfg_wdata_in, .cfg_rdata_out, .cfg_ack_out, .rom_req_out, .rom_addr_out,
		.rom_data_in, .rom_valid_in, .wake_event_in, .wake_out, .power_state_out(),
		.mem_bar_enable_out, .load_done_out);
	ecl_rom_model u_rom (.clk_in(sys_clk_in), .rst_in, .delay_in(dly), .req_in(rom_req_out),
		.image_in({{9{16'hffff}}, {3{16'hbeef}}, w0 ^ 16'h0f0f, ~w0, 16'hbeef, w0}),
		.addr_in(rom_addr_out), .data_out(rom_data_in), .valid_out(rom_valid_in));
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one configuration cycle, answer sampled mid-cycle
	task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		@(posedge sys_clk_in);
		cfg_req_in <= 1'b1;
		cfg_write_in <= w;
		cfg_addr_in <= a;
		cfg_byte_en_in <= be;
		cfg_wdata_in <= d;
		@(posedge sys_clk_in);
		cfg_req_in <= 1'b0;
		@(negedge sys_clk_in);
		r = cfg_rdata_out;
		cmp("ack", 32'h1, {31'h0, cfg_ack_out});
	endtask
	task automatic end_of_test;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic load;
		repeat (12) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		acc(1'b0, 8'h2c, 4'h0, 32'h0);
		cmp("board default", 32'h0, r);
		for (int i = 0; i < 300 && load_done_out !== 1'b1; i++) @(posedge sys_clk_in);
		if (load_done_out !== 1'b1) begin
			errors++;
			end_of_test();
		end
	endtask
	task automatic check_fields;
		acc(1'b0, 8'h2c, 4'h0, 32'h0);
		cmp("board ids", {w0 ^ 16'h0f0f, ~w0}, r);
		acc(1'b0, 8'h00, 4'h0, 32'h0);
		cmp("maker", {16'h0, MAKER}, {16'h0, r[15:0]});
		acc(1'b0, 8'h08, 4'h0, 32'h0);
		cmp("revision", {24'h0, REV}, r & 32'hff);
		acc(1'b0, 8'h04, 4'h0, 32'h0);
		cmp("fast cap", {31'h0, w0[0]}, {31'h0, r[23]});
		acc(1'b0, 8'h10, 4'h0, 32'h0);
		cmp("bar", {29'h0, w0[1] & ~w0[2], 2'h0}, w0[2] ? r : r & 32'h4);
		cmp("bar enable", {31'h0, ~w0[2]}, {31'h0, mem_bar_enable_out});
		acc(1'b0, 8'h50, 4'h0, 32'h0);
		cmp("power cap", {25'h0, w0[3], 1'b1, w0[5:4], 1'b1, w0[5:4]}, r >> 25);
		acc(1'b0, 8'h3c, 4'h0, 32'h0);
		cmp("grant latency", {23'h0, w0[15:7]}, {23'h0, r[29:25], r[23:20]});
		acc(1'b0, 8'h54, 4'h0, 32'h0);
		cmp("wake enable", {31'h0, w0[6]}, {31'h0, r[8]});
	endtask
	// main sequence
	initial begin
		load();
		check_fields();
		foreach (ro_addr[i]) acc(1'b1, ro_addr[i], 4'hf, 32'hffff_ffff);
		check_fields();
		$display("test load and read-only done");
		wake_event_in <= 1'b1;
		repeat (6) @(posedge sys_clk_in);
		acc(1'b0, 8'h54, 4'h0, 32'h0);
		cmp("wake status", 32'h1, {31'h0, r[15]});
		cmp("wake out", 32'h1, {31'h0, wake_out});
		for (int s = 0; s < 4; s++) begin
			acc(1'b1, 8'h54, 4'h2, 32'h8000 | (32'(s) << 9));
			acc(1'b0, 8'h54, 4'h0, 32'h0);
			cmp("data scale", 32'(s), {30'h0, r[14:13]});
		end
		wake_event_in <= 1'b0;
		repeat (4) @(posedge sys_clk_in);
		wake_event_in <= 1'b1;
		repeat (6) @(posedge sys_clk_in);
		acc(1'b0, 8'h54, 4'h0, 32'h0);
		cmp("wake status", 32'h1, {31'h0, r[15]});
		cmp("wake out", 32'h0, {31'h0, wake_out});
		$display("test wake and scale done");
		w0 = 16'h5a2c;
		dly <= 4'h0;
		rst_in <= 1'b1;
		load();
		check_fields();
		$display("test reload done");
		end_of_test();
	end
endmodule // tb_top
